/* File: design/pri_port_ram_access.sv */
// Port RAM with indirect host access, live timeslot bytes and receive routing.
// Assumes framer strobes synchronous to clk_i and an AXI4-Lite master.
`timescale 1ns/1ps
module pri_port_ram_access
  import pri_pkg::*;
#(
  parameter int unsigned ADDR_W = pri_pkg::AXI_ADDR_W
) (
  input  wire logic                         clk_i,
  input  wire logic                         srst_i,
  input  wire logic                         s_axi_awvalid_i,
  input  wire logic [ADDR_W-1:0]            s_axi_awaddr_i,
  output logic                              s_axi_awready_o,
  input  wire logic                         s_axi_wvalid_i,
  input  wire logic [pri_pkg::AXI_DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  output logic                              s_axi_wready_o,
  output logic                              s_axi_bvalid_o,
  output logic [1:0]                        s_axi_bresp_o,
  input  wire logic                         s_axi_bready_i,
  input  wire logic                         s_axi_arvalid_i,
  input  wire logic [ADDR_W-1:0]            s_axi_araddr_i,
  output logic                              s_axi_arready_o,
  output logic                              s_axi_rvalid_o,
  output logic [pri_pkg::AXI_DATA_W-1:0]    s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  input  wire logic                         s_axi_rready_i,
  input  wire logic                         rx_slot_valid_i,
  input  wire pri_pkg::pri_slot_t           rx_slot_i,
  input  wire logic                         tx_slot_valid_i,
  input  wire pri_pkg::pri_slot_t           tx_slot_i,
  output logic                              hdlc_valid_o,
  output pri_pkg::pri_hdlc_t                hdlc_o,
  output logic                              tester_valid_o,
  output pri_pkg::pri_tester_t              tester_o,
  output logic                              search_valid_o,
  output logic [7:0]                        search_octet_o,
  output logic                              tx_slot_valid_o,
  output logic [15:0]                       tx_cfg_o,
  output logic [7:0]                        tx_live_rx_o
);
  import pri_pkg::*;

  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W must cover the four register words");
  end

  // ==========================================================
  // Storage
  logic [7:0]       live_rx_q [NUM_TS];
  logic [7:0]       live_tx_q [NUM_TS];
  logic [15:0]      rx_cfg_q  [NUM_TS];
  logic [15:0]      tx_cfg_q  [NUM_TS];

  pri_state_t       state_q;
  logic [TS_W-1:0]  sel_index_q;
  pri_msel_t        sel_msel_q;
  logic             sel_dir_q;
  logic [15:0]      data_q;
  logic             unch_q;
  logic             illegal_q;

  logic             aw_pend_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic             w_pend_q;
  logic [15:0]      w_data_q;
  logic [1:0]       w_strb_q;
  logic             awready_q;
  logic             wready_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             arready_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  // ==========================================================
  // AXI4-Lite write channel
  logic             wr_fire;
  logic             wr_mapped;
  logic [3:0]       wr_off;
  logic             busy;
  logic             exec;

  assign busy      = (state_q == ST_RUN);
  // Framer traffic owns the RAM; the host access waits out any strobe cycle
  assign exec      = busy && !rx_slot_valid_i && !tx_slot_valid_i;
  assign wr_fire   = aw_pend_q && w_pend_q && !bvalid_q;
  assign wr_mapped = (aw_addr_q >> 4) == '0;
  assign wr_off    = {aw_addr_q[3:2], 2'b00};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_pend_q <= 1'b0;
      aw_addr_q <= '0;
      awready_q <= 1'b1;
      w_pend_q  <= 1'b0;
      w_data_q  <= 16'h0000;
      w_strb_q  <= 2'b00;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        aw_pend_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q) begin
        w_pend_q <= 1'b1;
        w_data_q <= s_axi_wdata_i[15:0];
        w_strb_q <= s_axi_wstrb_i[1:0];
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_pend_q <= 1'b0;
        w_pend_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_mapped ? RESP_OKAY : RESP_SLV;
      end
      // One write in flight: address and data reopen after the response
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Selector, mode and access sequencer
  logic sel_wr;
  logic data_wr;

  assign sel_wr  = wr_fire && wr_mapped && wr_off == OFF_SELECT;
  assign data_wr = wr_fire && wr_mapped && wr_off == OFF_DATA;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q     <= ST_IDLE;
      sel_index_q <= SELECT_RST[SEL_INDEX_LSB +: TS_W];
      sel_msel_q  <= pri_msel_t'(SELECT_RST[SEL_MSEL_LSB +: 2]);
      sel_dir_q   <= SELECT_RST[SEL_DIR_BIT];
    end else begin
      case (state_q)
        ST_IDLE: begin
          // A selector write while busy is dropped so the access in flight stays intact
          if (sel_wr) begin
            if (w_strb_q[0]) begin
              sel_index_q <= w_data_q[SEL_INDEX_LSB +: TS_W];
            end
            if (w_strb_q[1]) begin
              sel_msel_q <= pri_msel_t'(w_data_q[SEL_MSEL_LSB +: 2]);
              sel_dir_q  <= w_data_q[SEL_DIR_BIT];
            end
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (exec) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      unch_q <= 1'b0;
    end else if (wr_fire && wr_mapped && wr_off == OFF_MODE && w_strb_q[0]) begin
      unch_q <= w_data_q[MODE_UNCH_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      illegal_q <= 1'b0;
    end else if (exec) begin
      illegal_q <= (sel_msel_q == MSEL_ILLEGAL);
    end
  end

  // ==========================================================
  // Data register and RAM
  logic [15:0] entry_rd;

  always_comb begin
    case (sel_msel_q)
      MSEL_LIVE:  entry_rd = {live_tx_q[sel_index_q], live_rx_q[sel_index_q]};
      MSEL_RXCFG: entry_rd = rx_cfg_q[sel_index_q];
      MSEL_TXCFG: entry_rd = tx_cfg_q[sel_index_q];
      default:    entry_rd = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_q <= DATA_RST;
    end else if (exec && sel_dir_q) begin
      data_q <= entry_rd;
    end else if (data_wr && !busy) begin
      data_q <= merge16(data_q, w_data_q, w_strb_q);
    end
  end

  // Live bytes: framer strobes and host stores never share a cycle
  always_ff @(posedge clk_i) begin
    if (rx_slot_valid_i) begin
      live_rx_q[rx_slot_i.index] <= rx_slot_i.octet;
    end else if (exec && !sel_dir_q && sel_msel_q == MSEL_LIVE) begin
      live_rx_q[sel_index_q] <= data_q[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (tx_slot_valid_i) begin
      live_tx_q[tx_slot_i.index] <= tx_slot_i.octet;
    end else if (exec && !sel_dir_q && sel_msel_q == MSEL_LIVE) begin
      live_tx_q[sel_index_q] <= data_q[15:8];
    end
  end

  // Config entries hold no reset value; software must load them
  always_ff @(posedge clk_i) begin
    if (exec && !sel_dir_q && sel_msel_q == MSEL_RXCFG) begin
      rx_cfg_q[sel_index_q] <= data_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (exec && !sel_dir_q && sel_msel_q == MSEL_TXCFG) begin
      tx_cfg_q[sel_index_q] <= data_q;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic        rd_mapped;
  logic [3:0]  rd_off;
  logic [15:0] rd_word;
  logic [15:0] sel_view;

  assign rd_mapped = (s_axi_araddr_i >> 4) == '0;
  assign rd_off    = {s_axi_araddr_i[3:2], 2'b00};
  assign sel_view  = {busy, sel_dir_q, 4'h0, sel_msel_q, 1'b0, sel_index_q};

  always_comb begin
    case (rd_off)
      OFF_SELECT: rd_word = sel_view;
      OFF_DATA:   rd_word = data_q;
      OFF_MODE:   rd_word = {15'h0000, unch_q};
      OFF_STATUS: rd_word = {14'h0000, illegal_q, busy};
      default:    rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_mapped ? {16'h0000, rd_word} : 32'h0000_0000;
        rresp_q   <= rd_mapped ? RESP_OKAY : RESP_SLV;
      end
      if (rvalid_q && s_axi_rready_i) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Receive routing
  pri_rx_cfg_t cfg_ts;
  pri_rx_cfg_t cfg_0;
  logic        loop_on;
  logic        seven_on;
  logic [7:0]  line_octet;

  assign cfg_ts     = pri_rx_cfg_t'(rx_cfg_q[rx_slot_i.index]);
  assign cfg_0      = pri_rx_cfg_t'(rx_cfg_q[0]);
  assign seven_on   = !unch_q && cfg_ts.seven;
  assign loop_on    = !unch_q && cfg_ts.local_loop && cfg_ts.enable && !cfg_ts.seven;
  assign line_octet = loop_on ? live_tx_q[rx_slot_i.index] : rx_slot_i.octet;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hdlc_valid_o <= 1'b0;
      hdlc_o       <= '0;
    end else begin
      hdlc_valid_o   <= rx_slot_valid_i && (unch_q ? cfg_0.enable : cfg_ts.enable);
      hdlc_o.channel <= unch_q ? cfg_0.channel : cfg_ts.channel;
      hdlc_o.octet   <= seven_on ? {line_octet[7:1], 1'b0} : line_octet;
      hdlc_o.seven   <= seven_on;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tester_valid_o <= 1'b0;
      tester_o       <= '0;
    end else begin
      tester_valid_o <= rx_slot_valid_i && (unch_q ? cfg_0.tester : cfg_ts.tester);
      tester_o.octet <= seven_on ? {line_octet[7:1], 1'b0} : line_octet;
      tester_o.seven <= seven_on;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      search_valid_o <= 1'b0;
      search_octet_o <= 8'h00;
    end else begin
      search_valid_o <= rx_slot_valid_i && (unch_q || cfg_ts.search);
      search_octet_o <= line_octet;
    end
  end

  // Transmit side gets its config and the replay byte for network loop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_slot_valid_o <= 1'b0;
      tx_cfg_o        <= 16'h0000;
      tx_live_rx_o    <= 8'h00;
    end else begin
      tx_slot_valid_o <= tx_slot_valid_i;
      tx_cfg_o        <= tx_cfg_q[tx_slot_i.index];
      tx_live_rx_o    <= live_rx_q[tx_slot_i.index];
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  // ==========================================================
  // Checks
  a_busy_on_start: assert property (@(posedge clk_i) disable iff (srst_i)
    (sel_wr && !busy) |=> busy && sel_view[SEL_BUSY_BIT])
    else $error("busy not raised by selector write");

  a_busy_release: assert property (@(posedge clk_i) disable iff (srst_i)
    (busy && !rx_slot_valid_i && !tx_slot_valid_i) |=> !busy)
    else $error("busy held after a free cycle");

  a_read_result: assert property (@(posedge clk_i) disable iff (srst_i)
    (exec && sel_dir_q && sel_msel_q == MSEL_RXCFG)
      |=> data_q == rx_cfg_q[$past(sel_index_q)] && !busy)
    else $error("fetched entry not in data register");

  a_write_store: assert property (@(posedge clk_i) disable iff (srst_i)
    (exec && !sel_dir_q && sel_msel_q == MSEL_TXCFG)
      |=> tx_cfg_q[$past(sel_index_q)] == $past(data_q))
    else $error("stored entry differs from data register");

  a_sel_index: assert property (@(posedge clk_i) disable iff (srst_i)
    (sel_wr && !busy && w_strb_q[0])
      |=> sel_view[TS_W-1:0] == $past(w_data_q[TS_W-1:0]))
    else $error("timeslot index not taken");

  a_live_rx: assert property (@(posedge clk_i) disable iff (srst_i)
    rx_slot_valid_i |=> live_rx_q[$past(rx_slot_i.index)] == $past(rx_slot_i.octet))
    else $error("live receive byte not updated");

  a_live_tx: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_slot_valid_i |=> live_tx_q[$past(tx_slot_i.index)] == $past(tx_slot_i.octet))
    else $error("live transmit byte not updated");

  a_seven_drop: assert property (@(posedge clk_i) disable iff (srst_i)
    (rx_slot_valid_i && !unch_q && cfg_ts.seven)
      |=> hdlc_o.seven && hdlc_o.octet[0] == 1'b0 && tester_o.octet[0] == 1'b0)
    else $error("seven-bit slot kept its LSB");

  a_local_loop: assert property (@(posedge clk_i) disable iff (srst_i)
    (rx_slot_valid_i && !unch_q && cfg_ts.local_loop && cfg_ts.enable && !cfg_ts.seven)
      |=> hdlc_o.octet == $past(live_tx_q[rx_slot_i.index]))
    else $error("local loop byte not substituted");

  a_search_full: assert property (@(posedge clk_i) disable iff (srst_i)
    (rx_slot_valid_i && !loop_on) |=> search_octet_o == $past(rx_slot_i.octet))
    else $error("search byte altered");

  a_search_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    search_valid_o |-> $past(rx_slot_valid_i && (unch_q || cfg_ts.search)))
    else $error("slot searched without enable");

  a_unch_channel: assert property (@(posedge clk_i) disable iff (srst_i)
    (rx_slot_valid_i && unch_q) |=> hdlc_o.channel == $past(cfg_0.channel))
    else $error("unchannelized channel not from entry 0");

endmodule : pri_port_ram_access

/* File: design/pri_pkg.sv */
// Shared constants and types for the port RAM indirect access block.
// Assumes one instance per serial port, clocked by the host register clock.
package pri_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned NUM_TS     = 128;
  localparam int unsigned TS_W       = 7;
  localparam int unsigned ENTRY_W    = 16;
  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned AXI_DATA_W = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] OFF_SELECT = 4'h0;
  localparam logic [3:0] OFF_DATA   = 4'h4;
  localparam logic [3:0] OFF_MODE   = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hC;

  // ==========================================================
  // Field positions
  localparam int unsigned SEL_INDEX_LSB = 0;
  localparam int unsigned SEL_MSEL_LSB  = 8;
  localparam int unsigned SEL_DIR_BIT   = 14;
  localparam int unsigned SEL_BUSY_BIT  = 15;
  localparam int unsigned MODE_UNCH_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_ILL_BIT  = 1;

  // ==========================================================
  // Reset values and bus answers
  localparam logic [15:0] SELECT_RST = 16'h0000;
  localparam logic [15:0] DATA_RST   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  typedef enum logic [1:0] {
    MSEL_LIVE    = 2'h0,
    MSEL_RXCFG   = 2'h1,
    MSEL_TXCFG   = 2'h2,
    MSEL_ILLEGAL = 2'h3
  } pri_msel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } pri_state_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       enable;
    logic       tester;
    logic       rsv13;
    logic       search;
    logic       rsv11;
    logic       local_loop;
    logic       rsv9;
    logic       seven;
    logic [7:0] channel;
  } pri_rx_cfg_t;

  typedef struct packed {
    logic [TS_W-1:0] index;
    logic [7:0]      octet;
  } pri_slot_t;

  typedef struct packed {
    logic [7:0] channel;
    logic [7:0] octet;
    logic       seven;
  } pri_hdlc_t;

  typedef struct packed {
    logic [7:0] octet;
    logic       seven;
  } pri_tester_t;

endpackage : pri_pkg

/* File: verification/pri_port_ram_access_test.sv */
// Self-checking bench for the port RAM indirect access block.
// Assumes pri_pkg and pri_port_ram_access are compiled first; bench is AXI master and framer.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("FAIL %s expected %h seen %h", n, e, a); end end
module pri_port_ram_access_test;
  import pri_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [11:0] A_SEL  = {8'h00, OFF_SELECT};
  localparam logic [11:0] A_DATA = {8'h00, OFF_DATA};
  localparam logic [11:0] A_MODE = {8'h00, OFF_MODE};
  localparam logic [11:0] A_STAT = {8'h00, OFF_STATUS};
  // Memory select, index and the value written then read back
  localparam logic [24:0] ROWS [4] = '{{2'h1, 7'h00, 16'hFFFF}, {2'h1, 7'h7F, 16'h1234},
                                       {2'h2, 7'h00, 16'hA55A}, {2'h2, 7'h7F, 16'h0001}};
  logic        clk_i   = 1'b0;
  logic        srst_i  = 1'b1;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'hF;
  logic        rx_v    = 1'b0;
  logic        tx_v    = 1'b0;
  pri_slot_t   rx_slot = '0;
  pri_slot_t   tx_slot = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        hdlc_valid_o, tester_valid_o, search_valid_o, tx_slot_valid_o;
  pri_hdlc_t   hdlc_o;
  pri_tester_t tester_o;
  logic [7:0]  search_octet_o, tx_live_rx_o;
  logic [15:0] tx_cfg_o;
  int          errors       = 0;
  int          total_checks = 0;

  pri_port_ram_access pri_port_ram_access_i (
    .clk_i(clk_i), .srst_i(srst_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awaddr_i(awaddr), .s_axi_awready_o(awready),
    .s_axi_wvalid_i(wvalid), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wready_o(wready), .s_axi_bvalid_o(bvalid), .s_axi_bresp_o(bresp),
    .s_axi_bready_i(bready), .s_axi_arvalid_i(arvalid), .s_axi_araddr_i(araddr),
    .s_axi_arready_o(arready), .s_axi_rvalid_o(rvalid), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rready_i(rready),
    .rx_slot_valid_i(rx_v), .rx_slot_i(rx_slot), .tx_slot_valid_i(tx_v), .tx_slot_i(tx_slot),
    .hdlc_valid_o(hdlc_valid_o), .hdlc_o(hdlc_o), .tester_valid_o(tester_valid_o),
    .tester_o(tester_o), .search_valid_o(search_valid_o), .search_octet_o(search_octet_o),
    .tx_slot_valid_o(tx_slot_valid_o), .tx_cfg_o(tx_cfg_o), .tx_live_rx_o(tx_live_rx_o)
  );

  // ==========================================================
  // Bus and framer tasks
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    int   n;
    aw = 1'b1;
    w  = 1'b1;
    n  = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while ((aw || w) && n < 50) begin
      @(posedge clk_i);
      n++;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    r = bresp;
    bready <= 1'b0;
    // Let an edge pass so the next call never re-raises a strobe in this step
    @(posedge clk_i);
    `CHK("write handshake", 1'b1, n < 50)
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (rvalid !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
      if (arready === 1'b1) begin
        arvalid <= 1'b0;
      end
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Without this edge a following read would still see this rvalid
    @(posedge clk_i);
    `CHK("read handshake", 1'b1, n < 50)
  endtask : axr

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    d = 32'h0000_8000;
    while (d[15] !== 1'b0 && n < 40) begin
      axr(A_SEL, d, r);
      n++;
    end
    `CHK("busy clears", 1'b0, d[15])
  endtask : wait_idle

  // Write stores v into the entry; read returns the entry in v
  task automatic ind(input logic rd, input logic [1:0] m, input logic [6:0] i,
                     inout logic [15:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    if (!rd) axw(A_DATA, {16'h0000, v}, r);
    axw(A_SEL, {17'h0_0000, rd, 4'h0, m, 1'b0, i}, r);
    wait_idle();
    if (rd) begin
      axr(A_DATA, d, r);
      v = d[15:0];
    end
  endtask : ind

  // One framer byte; returns on the second edge, before the outputs move on
  task automatic slot(input logic tx, input logic [6:0] i, input logic [7:0] o);
    rx_slot <= {i, o};
    tx_slot <= {i, o};
    rx_v    <= !tx;
    tx_v    <= tx;
    @(posedge clk_i);
    rx_v <= 1'b0;
    tx_v <= 1'b0;
    @(posedge clk_i);
  endtask : slot

  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, errors);
  endtask : done

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Whole run needs about 230 cycles
  initial begin
    repeat (8000) @(posedge clk_i);
    errors++;
    $display("FAIL watchdog expected completion seen hang");
    stop_test();
  end

  initial begin
    logic [15:0] v;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    axr(A_SEL, d, r);
    `CHK("select reset", 32'h0000_0000, d)
    axr(A_DATA, d, r);
    `CHK("data reset", 32'h0000_0000, d)
    done("reset");
    // Config entries hold no reset value, so each one used is loaded first
    for (int k = 0; k < 4; k++) begin
      v = ROWS[k][15:0];
      ind(1'b0, ROWS[k][24:23], ROWS[k][22:16], v);
    end
    for (int k = 0; k < 4; k++) begin
      v = 16'h0000;
      ind(1'b1, ROWS[k][24:23], ROWS[k][22:16], v);
      `CHK("config readback", ROWS[k][15:0], v)
    end
    done("table");
    // Slot 5: enabled, tester, search, 56k, channel code 12h
    v = 16'hD112;
    ind(1'b0, 2'h1, 7'h05, v);
    slot(1'b0, 7'h05, 8'hA5);
    `CHK("hdlc valid", 1'b1, hdlc_valid_o)
    `CHK("hdlc 56k", 17'h0_2549, hdlc_o)
    `CHK("tester 56k", 9'h149, tester_o)
    `CHK("tester valid", 1'b1, tester_valid_o)
    `CHK("search full", 8'hA5, search_octet_o)
    done("seven bit");
    // Slot 6: enabled, local loop, channel 33h, no search
    v = 16'h8433;
    ind(1'b0, 2'h1, 7'h06, v);
    v = 16'h4C21;
    ind(1'b0, 2'h2, 7'h06, v);
    slot(1'b1, 7'h06, 8'h77);
    `CHK("tx echo", 1'b1, tx_slot_valid_o)
    `CHK("tx config", 16'h4C21, tx_cfg_o)
    slot(1'b0, 7'h06, 8'h11);
    `CHK("local loop", 17'h0_66EE, hdlc_o)
    `CHK("no search", 1'b0, search_valid_o)
    `CHK("no tester", 1'b0, tester_valid_o)
    slot(1'b1, 7'h06, 8'h78);
    `CHK("live rx byte", 8'h11, tx_live_rx_o)
    // Live entries are only read back here; this bench never stores one from the host
    ind(1'b1, 2'h0, 7'h06, v);
    `CHK("live entry", 16'h7811, v)
    done("loop and live");
    // Framer strobes every cycle keep the fetch waiting
    rx_slot <= {7'h05, 8'h3C};
    rx_v    <= 1'b1;
    axw(A_SEL, 32'h0000_4100, r);
    // A selector write while busy must leave the access alone
    axw(A_SEL, 32'h0000_0205, r);
    `CHK("busy select okay", 2'h0, r)
    axr(A_SEL, d, r);
    `CHK("busy during read", 32'h0000_C100, d)
    axr(A_STAT, d, r);
    `CHK("status busy", 32'h0000_0001, d)
    rx_v <= 1'b0;
    wait_idle();
    axr(A_DATA, d, r);
    `CHK("fetched entry", 32'h0000_FFFF, d)
    done("busy");
    ind(1'b1, 2'h3, 7'h00, v);
    `CHK("illegal read", 16'h0000, v)
    axr(A_STAT, d, r);
    `CHK("illegal flag", 32'h0000_0002, d)
    axr(12'h010, d, r);
    `CHK("unmapped read", 2'h2, r)
    axw(12'h010, 32'h0000_FFFF, r);
    `CHK("unmapped write", 2'h2, r)
    done("illegal");
    axw(A_MODE, 32'h0000_0001, r);
    slot(1'b0, 7'h06, 8'h11);
    `CHK("unch channel", 17'h1_FE22, hdlc_o)
    `CHK("unch tester", 9'h022, tester_o)
    `CHK("unch search", 1'b1, search_valid_o)
    done("unchannelized");
    // Low byte strobe only: the high byte of the data register must survive
    axw(A_DATA, 32'h0000_1234, r);
    wstrb <= 4'h1;
    axw(A_DATA, 32'h0000_ABCD, r);
    wstrb <= 4'hF;
    axr(A_DATA, d, r);
    `CHK("byte strobe", 32'h0000_12CD, d)
    done("byte strobe");
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("reset hdlc", 1'b0, hdlc_valid_o)
    axr(A_DATA, d, r);
    `CHK("data re-reset", 32'h0000_0000, d)
    axr(A_MODE, d, r);
    `CHK("mode re-reset", 32'h0000_0000, d)
    done("second reset");
    stop_test();
  end
endmodule : pri_port_ram_access_test
